// >>> wdt_top.sv
// Watchdog timer with configuration lock for a supply sequencer.
// Assumes a byte register port from the serial interface on the same clock.
`timescale 1ns/100ps
`default_nettype none
module wdt_top
    import wdt_pkg::*;
#(
    parameter int BASE_CNT = BASE_CYCLES
)
(
    // Clock, reset and enable.
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST_B,
    input  wire logic       I_CE,
    // Register port.
    input  wire logic       I_REG_WR,
    input  wire logic [7:0] I_REG_ADDR,
    input  wire logic [7:0] I_REG_WDATA,
    output var  logic [7:0] O_REG_RDATA,
    // Clear sources and outputs.
    input  wire logic [3:0] I_GENERAL_INPUT_N,
    input  wire logic [7:0] I_PROGRAMMABLE_OUTPUT_N,
    input  wire logic [7:0] I_WD_DEPENDENT,
    output var  logic [7:0] O_WD_ASSERT,
    output var  logic       O_WD_TIMEOUT,
    output var  logic       O_CONFIG_LOCKED
);

    logic [3:0]       gin_sync;
    logic [7:0]       src_sel;
    logic [7:0]       period_reg;
    logic [7:0]       lock_reg;
    logic [7:0]       next_src_sel;
    logic [7:0]       next_period_reg;
    logic [7:0]       next_lock_reg;
    logic [7:0]       next_rdata;
    logic [CNT_W-1:0] norm_cycles;
    logic [CNT_W-1:0] init_cycles;

    wdt_sync #(.W(4)) u_sync
    (
        .clk   (I_REF_CLK),
        .rst_b (I_RST_B),
        .ce    (I_CE),
        .d     (I_GENERAL_INPUT_N),
        .q     (gin_sync)
    );

    // Register bank with lock guard.
    always_comb
    begin
        next_src_sel    = src_sel;
        next_period_reg = period_reg;
        next_lock_reg   = lock_reg;
        if (I_CE && I_REG_WR)
        begin
            if (I_REG_ADDR == LOCK_ADDR)
                next_lock_reg = {7'h00, I_REG_WDATA[LOCK_BIT]};
            else if (!lock_reg[LOCK_BIT])
            begin
                if (I_REG_ADDR == SRC_SEL_ADDR)
                    next_src_sel = I_REG_WDATA;
                if (I_REG_ADDR == PERIOD_ADDR)
                    next_period_reg = {1'b0, I_REG_WDATA[6:0]};
            end
        end
        unique case (I_REG_ADDR)
            SRC_SEL_ADDR: next_rdata = src_sel;
            PERIOD_ADDR:  next_rdata = period_reg;
            LOCK_ADDR:    next_rdata = lock_reg;
            default:      next_rdata = 8'h00;
        endcase
        if (!I_CE)
            next_rdata = O_REG_RDATA;
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            src_sel         <= SRC_SEL_RESET;
            period_reg      <= PERIOD_RESET;
            lock_reg        <= LOCK_RESET;
            O_REG_RDATA     <= 8'h00;
            O_CONFIG_LOCKED <= 1'b0;
        end
        else
        begin
            src_sel         <= next_src_sel;
            period_reg      <= next_period_reg;
            lock_reg        <= next_lock_reg;
            O_REG_RDATA     <= next_rdata;
            O_CONFIG_LOCKED <= next_lock_reg[LOCK_BIT];
        end
    end

    // Period lookups add one cycle of latency, far inside the settling budget.
    wdt_period #(.BASE_CNT(BASE_CNT)) u_norm
    (
        .clk    (I_REF_CLK),
        .rst_b  (I_RST_B),
        .ce     (I_CE),
        .code   (period_reg[NORM_LSB +: 3]),
        .cycles (norm_cycles)
    );

    wdt_period #(.BASE_CNT(BASE_CNT)) u_init
    (
        .clk    (I_REF_CLK),
        .rst_b  (I_RST_B),
        .ce     (I_CE),
        .code   (period_reg[INIT_LSB +: 3]),
        .cycles (init_cycles)
    );

    // Source selection and edge detection.
    logic       gin_sel;
    logic       pout_sel;
    logic       gin_prev;
    logic       pout_prev;
    logic       gin_seen;
    logic       pout_seen;
    logic       next_gin_prev;
    logic       next_pout_prev;
    logic       next_gin_seen;
    logic       next_pout_seen;
    logic       gin_edge;
    logic       pout_edge;
    logic       clear_evt;
    logic [1:0] dep;

    always_comb
    begin
        gin_sel   = gin_sync[src_sel[GIN_SEL_LSB +: 2]];
        pout_sel  = I_PROGRAMMABLE_OUTPUT_N[src_sel[POUT_SEL_LSB +: 3]];
        dep       = src_sel[DEP_LSB +: 2];
        gin_edge  = gin_sel != gin_prev;
        pout_edge = pout_sel != pout_prev;
        unique case (dep)
            DEP_POUT:   clear_evt = pout_edge;
            DEP_GIN:    clear_evt = gin_edge;
            DEP_BOTH_A,
            DEP_BOTH_B: clear_evt = (gin_edge || gin_seen) && (pout_edge || pout_seen);
        endcase
    end

    // Timer state machine.
    wd_state_type     state;
    wd_state_type     next_state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_timeout;
    logic [7:0]       next_assert;
    logic             enable;

    assign enable = period_reg[ENABLE_BIT];

    always_comb
    begin
        next_state     = state;
        next_count     = count;
        next_timeout   = O_WD_TIMEOUT;
        next_assert    = O_WD_ASSERT;
        next_gin_prev  = gin_prev;
        next_pout_prev = pout_prev;
        next_gin_seen  = gin_seen;
        next_pout_seen = pout_seen;
        if (I_CE)
        begin
            next_gin_prev  = gin_sel;
            next_pout_prev = pout_sel;
            next_gin_seen  = gin_seen || gin_edge;
            next_pout_seen = pout_seen || pout_edge;
            unique case (state)
                ST_OFF:
                begin
                    next_timeout   = 1'b0;
                    next_count     = '0;
                    next_gin_seen  = 1'b0;
                    next_pout_seen = 1'b0;
                    if (enable)
                        next_state = ST_INITIAL;
                end
                ST_INITIAL,
                ST_NORMAL:
                begin
                    next_count = count + CNT_W'(1);
                    if (!enable)
                    begin
                        next_state   = ST_OFF;
                        next_timeout = 1'b0;
                    end
                    else if (clear_evt)
                    begin
                        next_count     = '0;
                        next_timeout   = 1'b0;
                        next_gin_seen  = 1'b0;
                        next_pout_seen = 1'b0;
                        next_state     = ST_NORMAL;
                    end
                    else if (next_count >= (state == ST_INITIAL ? init_cycles : norm_cycles))
                    begin
                        // Fault: a missed clear in either period flags the processor.
                        next_timeout   = 1'b1;
                        next_count     = '0;
                        next_gin_seen  = 1'b0;
                        next_pout_seen = 1'b0;
                        next_state     = ST_NORMAL;
                    end
                end
                default:
                    next_state = ST_OFF;
            endcase
            next_assert = next_timeout ? I_WD_DEPENDENT : 8'h00;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            state        <= ST_OFF;
            count        <= '0;
            O_WD_TIMEOUT <= 1'b0;
            O_WD_ASSERT  <= 8'h00;
            gin_prev     <= 1'b0;
            pout_prev    <= 1'b0;
            gin_seen     <= 1'b0;
            pout_seen    <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            count        <= next_count;
            O_WD_TIMEOUT <= next_timeout;
            O_WD_ASSERT  <= next_assert;
            gin_prev     <= next_gin_prev;
            pout_prev    <= next_pout_prev;
            gin_seen     <= next_gin_seen;
            pout_seen    <= next_pout_seen;
        end
    end

    // Checks.
    locked_write_drop_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && I_REG_WR && lock_reg[0] && I_REG_ADDR == PERIOD_ADDR)
        |=> $stable(period_reg)) else $error("locked write changed period");
    unlock_write_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && I_REG_WR && I_REG_ADDR == LOCK_ADDR)
        |=> lock_reg[0] == $past(I_REG_WDATA[0])) else $error("lock write lost");
    disabled_quiet_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && !enable) |=> !O_WD_TIMEOUT && O_WD_ASSERT == 8'h00)
        else $error("timeout while disabled");
    enable_initial_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && state == ST_OFF && enable) |=> state == ST_INITIAL)
        else $error("enable did not start initial period");
    clear_restart_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && state != ST_OFF && enable && clear_evt)
        |=> count == 0 && state == ST_NORMAL) else $error("clear did not restart");
    gin_only_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (dep == DEP_GIN) |-> clear_evt == gin_edge) else $error("input dependency wrong");
    pout_only_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (dep == DEP_POUT) |-> clear_evt == pout_edge) else $error("output dependency wrong");
    timeout_assert_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        $rose(O_WD_TIMEOUT) |-> O_WD_ASSERT == $past(I_WD_DEPENDENT))
        else $error("dependent outputs not asserted");
    initial_expiry_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && state == ST_INITIAL && enable && !clear_evt && count + 1 >= init_cycles)
        |=> O_WD_TIMEOUT && state == ST_NORMAL) else $error("initial expiry missed");
    normal_expiry_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && state == ST_NORMAL && enable && !clear_evt && count + 1 >= norm_cycles)
        |=> O_WD_TIMEOUT && count == 0) else $error("normal expiry missed");
    source_lock_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && I_REG_WR && lock_reg[LOCK_BIT] && I_REG_ADDR == SRC_SEL_ADDR)
        |=> $stable(src_sel)) else $error("locked write changed source select");
    both_wait_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && state != ST_OFF && enable && O_WD_TIMEOUT && !gin_seen && !gin_edge
        && (dep == DEP_BOTH_A || dep == DEP_BOTH_B))
        |=> O_WD_TIMEOUT) else $error("clear without both sources");
    clear_release_a: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        (I_CE && state == ST_NORMAL && enable && clear_evt)
        |=> !O_WD_TIMEOUT && O_WD_ASSERT == 8'h00) else $error("clear kept outputs asserted");

    enable_cov: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        state == ST_OFF ##1 state == ST_INITIAL);
    timeout_cov: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        $rose(O_WD_TIMEOUT));
    clear_cov: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        state == ST_NORMAL && clear_evt);
    pout_clear_cov: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        state == ST_NORMAL && dep == DEP_POUT && clear_evt);
    both_clear_cov: cover property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
        state == ST_NORMAL && (dep == DEP_BOTH_A || dep == DEP_BOTH_B) && clear_evt);

endmodule : wdt_top
`default_nettype wire

// >>> wdt_pkg.sv
// Shared constants for the sequencer watchdog and configuration lock.
// Assumes a 200 MHz reference clock and byte-wide register access.
package wdt_pkg;

    // Register offsets.
    localparam logic [7:0] SRC_SEL_ADDR   = 8'h3C;
    localparam logic [7:0] PERIOD_ADDR    = 8'h3D;
    localparam logic [7:0] LOCK_ADDR      = 8'h45;

    // Reset values.
    localparam logic [7:0] SRC_SEL_RESET  = 8'h80;
    localparam logic [7:0] PERIOD_RESET   = 8'h00;
    localparam logic [7:0] LOCK_RESET     = 8'h00;

    // Field positions of the source select register.
    localparam int GIN_SEL_LSB  = 0;
    localparam int POUT_SEL_LSB = 2;
    localparam int DEP_LSB      = 5;
    // Field positions of the period register and the lock register.
    localparam int NORM_LSB     = 0;
    localparam int INIT_LSB     = 3;
    localparam int ENABLE_BIT   = 6;
    localparam int LOCK_BIT     = 0;

    // Dependency codes.
    localparam logic [1:0] DEP_BOTH_A = 2'h0;
    localparam logic [1:0] DEP_POUT   = 2'h1;
    localparam logic [1:0] DEP_GIN    = 2'h2;
    localparam logic [1:0] DEP_BOTH_B = 2'h3;

    // Timing: the shortest period in nanoseconds, each code four times longer.
    localparam longint CLK_PERIOD_NS  = 5;
    localparam longint BASE_PERIOD_NS = 6250000;
    localparam int     BASE_CYCLES    = int'(BASE_PERIOD_NS / CLK_PERIOD_NS);
    localparam int     CNT_W          = 36;

    // Settling time for new configuration, and its count (rounded down).
    localparam longint APPLY_NS       = 5000;
    localparam int     APPLY_CYCLES   = int'(APPLY_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0]
    {
        ST_OFF     = 2'b00,
        ST_INITIAL = 2'b01,
        ST_NORMAL  = 2'b10
    } wd_state_type;

endpackage : wdt_pkg

// >>> wdt_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes the inputs are asynchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module wdt_sync
#(
    parameter int W = 4
)
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb
    begin
        next_meta = ce ? d : meta;
        next_q    = ce ? meta : q;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule : wdt_sync
`default_nettype wire

// >>> wdt_period.sv
// Period lookup: turns a 3-bit period code into a cycle count.
// Assumes the base count and multiplier spacing from the package.
`timescale 1ns/100ps
`default_nettype none
module wdt_period
    import wdt_pkg::*;
#(
    // Cycles in the shortest period; a smaller value shortens all eight codes alike.
    parameter int BASE_CNT = BASE_CYCLES
)
(
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [2:0]       code,
    output var  logic [CNT_W-1:0] cycles
);
    logic [CNT_W-1:0] next_cycles;

    // Each code step is four times the previous duration.
    always_comb
    begin
        next_cycles = ce ? (CNT_W'(BASE_CNT) << {code, 1'b0}) : cycles;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cycles <= CNT_W'(BASE_CNT);
        else
            cycles <= next_cycles;
    end
endmodule : wdt_period
`default_nettype wire

// >>> cpu_model.sv
// Processor model that pulses one general input as its watchdog clear.
// Assumes the bench clock; toggles are spaced i_gap+1 cycles apart while i_run is high.
`timescale 1ns/100ps
`default_nettype none
module cpu_model
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Control from the bench.
    input  wire logic       i_run,
    input  wire logic [1:0] i_sel,
    input  wire logic [7:0] i_gap,
    // Pulsed general inputs.
    output var  logic [3:0] o_gpi
);
    logic [7:0] count;

    // Pins move 1 ns after the edge, as a real port would, never on the sampling edge.
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count <= 8'h00;
            o_gpi <= #1 4'h0;
        end
        else if (i_run && count >= i_gap)
        begin
            count <= 8'h00;
            o_gpi[i_sel] <= #1 ~o_gpi[i_sel];
        end
        else
        begin
            count <= count + 8'h01;
        end
    end
endmodule : cpu_model
`default_nettype wire

// >>> sequencer_watchdog_and_config_lock_bench.sv
// Self-checking bench for the watchdog timer and configuration lock.
// Assumes the package constants; the base period is shortened so every expiry fits a short run.
`timescale 1ns/100ps
`default_nettype none
module sequencer_watchdog_and_config_lock_bench;
    import wdt_pkg::*;

    typedef struct {string name; logic [7:0] value;} note_type;

    // Cycles of the shortest period in this run; each code step is four times longer.
    localparam int BASE = 100;

    logic       clk;
    logic       rst_b;
    logic       ce;
    logic       wr;
    logic       run;
    logic       rd_chk;
    logic       timeout;
    logic       locked;
    logic       early;
    logic [1:0] sel;
    logic [2:0] psel;
    logic [3:0] gpi;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] pout;
    logic [7:0] dep;
    logic [7:0] wd_assert;
    logic [7:0] src;
    int         fails;
    int         comparisons;
    note_type   notes[$];
    note_type   n;

    wdt_top #(.BASE_CNT(BASE)) i_dut
    (
        .I_REF_CLK               (clk),
        .I_RST_B                 (rst_b),
        .I_CE                    (ce),
        .I_REG_WR                (wr),
        .I_REG_ADDR              (addr),
        .I_REG_WDATA             (wdata),
        .O_REG_RDATA             (rdata),
        .I_GENERAL_INPUT_N       (gpi),
        .I_PROGRAMMABLE_OUTPUT_N (pout),
        .I_WD_DEPENDENT          (dep),
        .O_WD_ASSERT             (wd_assert),
        .O_WD_TIMEOUT            (timeout),
        .O_CONFIG_LOCKED         (locked)
    );

    cpu_model i_cpu
    (
        .clk   (clk),
        .rst_b (rst_b),
        .i_run (run),
        .i_sel (sel),
        .i_gap (8'h14),
        .o_gpi (gpi)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask : reg_write

    // The note is queued now; the monitor compares once the registered data has settled.
    task automatic reg_read(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 addr = a;
        notes.push_back('{name, exp});
        @(posedge clk);
        #1 rd_chk = 1'b1;
        @(posedge clk);
        #1 rd_chk = 1'b0;
    endtask : reg_read

    task automatic wait_for(input logic level, input int limit);
        for (int i = 0; i < limit && timeout !== level; i++)
        begin
            @(posedge clk);
            #1;
        end
    endtask : wait_for

    // Flags any timeout seen before the given number of cycles has passed.
    task automatic expect_quiet(input int cycles);
        early = 1'b0;
        for (int i = 0; i < cycles; i++)
        begin
            @(posedge clk);
            #1;
            if (timeout !== 1'b0)
                early = 1'b1;
        end
    endtask : expect_quiet

    always @(posedge clk)
    begin
        if (rd_chk && notes.size() > 0)
        begin
            n = notes.pop_front();
            check(n.name, rdata, n.value);
        end
    end

    initial
    begin
        // About three times what the scenarios below should take.
        repeat (40 * BASE) @(posedge clk);
        fails++;
        summarize();
    end

    initial
    begin
        rst_b = 1'b0;
        ce = 1'b1;
        wr = 1'b0;
        run = 1'b0;
        rd_chk = 1'b0;
        early = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        void'($urandom(32'h4A242355));
        sel = 2'($urandom_range(3));
        pout = 8'($urandom);
        dep = 8'($urandom_range(255, 1));
        psel = 3'($urandom_range(7));
        src = {1'b1, DEP_GIN, psel, sel};
        repeat (5) @(posedge clk);
        #1 rst_b = 1'b1;
        // A write while the clock enable is low must leave the register at its reset value.
        ce = 1'b0;
        reg_write(PERIOD_ADDR, 8'h45);
        ce = 1'b1;
        reg_read("source select", SRC_SEL_ADDR, SRC_SEL_RESET);
        reg_read("period", PERIOD_ADDR, PERIOD_RESET);
        reg_read("lock", LOCK_ADDR, LOCK_RESET);
        reg_read("unmapped", 8'h44, 8'h00);
        reg_write(SRC_SEL_ADDR, src);
        reg_read("source select", SRC_SEL_ADDR, src);
        reg_write(PERIOD_ADDR, 8'hB7);
        reg_read("period", PERIOD_ADDR, 8'h37);
        reg_write(LOCK_ADDR, 8'hFF);
        reg_read("lock", LOCK_ADDR, 8'h01);
        check("locked flag", locked, 8'h01);
        reg_write(PERIOD_ADDR, 8'h40);
        reg_write(SRC_SEL_ADDR, 8'h80);
        reg_read("period", PERIOD_ADDR, 8'h37);
        reg_read("source select", SRC_SEL_ADDR, src);
        reg_write(LOCK_ADDR, 8'h00);
        reg_read("lock", LOCK_ADDR, 8'h00);
        check("locked flag", locked, 8'h00);
        // Enable with the initial period four times the normal one; nothing toggles meanwhile.
        reg_write(PERIOD_ADDR, 8'h48);
        expect_quiet(4 * BASE - 4);
        check("early timeout", early, 8'h00);
        wait_for(1'b1, 12);
        check("timeout", timeout, 8'h01);
        check("dependent outputs", wd_assert, dep);
        run = 1'b1;
        wait_for(1'b0, 40);
        check("timeout cleared", timeout, 8'h00);
        check("outputs released", wd_assert, 8'h00);
        run = 1'b0;
        // The next cycle runs on the short normal period.
        expect_quiet(BASE - 4);
        check("normal period early", early, 8'h00);
        wait_for(1'b1, 12);
        check("normal timeout", timeout, 8'h01);
        // Output dependency only: input toggles are ignored, an output toggle clears.
        reg_write(SRC_SEL_ADDR, {src[7], DEP_POUT, src[4:0]});
        run = 1'b1;
        wait_for(1'b0, 30);
        check("input ignored", timeout, 8'h01);
        run = 1'b0;
        @(posedge clk);
        #1 pout[psel] = ~pout[psel];
        wait_for(1'b0, 4);
        check("output clear", timeout, 8'h00);
        // Both sources: an output toggle alone does not clear, the input then completes it.
        wait_for(1'b1, BASE + 12);
        check("second normal timeout", timeout, 8'h01);
        reg_write(SRC_SEL_ADDR, {src[7], DEP_BOTH_A, src[4:0]});
        @(posedge clk);
        #1 pout[psel] = ~pout[psel];
        wait_for(1'b0, 8);
        check("output alone", timeout, 8'h01);
        run = 1'b1;
        wait_for(1'b0, 30);
        check("both cleared", timeout, 8'h00);
        run = 1'b0;
        // Disabling drops a pending timeout and keeps the watchdog quiet afterwards.
        wait_for(1'b1, BASE + 12);
        reg_write(PERIOD_ADDR, 8'h08);
        wait_for(1'b0, 4);
        check("disabled timeout", timeout, 8'h00);
        check("disabled outputs", wd_assert, 8'h00);
        expect_quiet(4 * BASE);
        check("disabled quiet", early, 8'h00);
        reg_read("period", PERIOD_ADDR, 8'h08);
        summarize();
    end
endmodule : sequencer_watchdog_and_config_lock_bench
`default_nettype wire
